// File: shared/arc_regs.vh
`ifndef ARC_REGS_VH
`define ARC_REGS_VH
// register offsets (byte addresses, one word each)
`define ARC_CTRL_OFS       8'h00
`define ARC_STATUS_OFS     8'h04
`define ARC_IRQ_STAT_OFS   8'h08
`define ARC_IRQ_MASK_OFS   8'h0c
`define ARC_DEAD1_OFS      8'h10
`define ARC_DEAD2_OFS      8'h14
`define ARC_RECL1_OFS      8'h18
`define ARC_RECL2_OFS      8'h1c
`define ARC_GRECL_OFS      8'h20
// control field positions
`define ARC_CTRL_SHOT1_EN  0
`define ARC_CTRL_SHOT2_EN  1
`define ARC_CTRL_GR_LOCK   2
`define ARC_CTRL_GR_SKIP   3
`define ARC_CTRL_RESET     4
// reset values
`define ARC_CTRL_RST       32'h0000_0007
`define ARC_DEAD1_RST      32'h0000_00c8
`define ARC_DEAD2_RST      32'h0000_ea60
`define ARC_RECL_RST       32'h0000_2710
`define ARC_GRECL_RST      32'h0000_2710
// timing: 1 ms tick at 40 MHz
`define ARC_CLK_KHZ        40000
`define ARC_TICK_MS        1
`define ARC_TICK_CYC       (`ARC_CLK_KHZ * `ARC_TICK_MS)
// interrupt status bits
`define ARC_EV_START       0
`define ARC_EV_CLOSE       1
`define ARC_EV_LOCKOUT     2
`define ARC_EV_READY       3
`endif

// File: logic/arc_ms_tick.v
`include "arc_regs.vh"
// millisecond tick generator shared by all sequence timers
module arc_ms_tick #(
    parameter integer TICK_CYC = `ARC_TICK_CYC
) (
    // clock and reset
    input  wire ref_clk_i,
    input  wire resetn_i,
    // tick out
    output reg  tick_o
);
    reg [31:0] cnt;

    // one-cycle pulse every TICK_CYC clocks
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            cnt    <= 32'h0000_0000;
            tick_o <= 1'b0;
        end else if (cnt == TICK_CYC - 1) begin
            cnt    <= 32'h0000_0000;
            tick_o <= 1'b1;
        end else begin
            cnt    <= cnt + 32'h0000_0001;
            tick_o <= 1'b0;
        end
    end
endmodule

// File: logic/arc_sequencer.v
`include "arc_regs.vh"
// Overview of operation
// - trip-driven requests start at once, no start or discrimination delay
// - request 2 trip sets active, request2 pending and first attempt together
// - dead time starts once breaker is open and request released
// - dead time expiry raises close request to breaker object
// - close held until breaker closed, then shot reclaim starts
// - request during reclaim with next shot enabled advances to second attempt
// - each shot has its own dead time setting
// - request in last reclaim with no shot left: final trip then lockout
// - lockout ignores requests until reset and breaker closed
// - reclaim expiry drops active flags and starts global reclaim
// - fault during global reclaim may go straight to lockout when set
// - zero-valued reclaim timers are bypassed
// - option skips global reclaim after successful cycle
// - global reclaim expiry returns to ready
// - five prioritised requests, critical request stops reclosing anywhere
// - breaker open or close failure forces lockout
// - lockout cleared by reset input or control reset bit, once breaker closed
module arc_sequencer #(
    parameter integer TICK_CYC = `ARC_TICK_CYC
) (
    // clock and reset
    input  wire        ref_clk_i,
    input  wire        resetn_i,
    // register port
    input  wire [7:0]  reg_addr_i,
    input  wire [31:0] reg_wdata_i,
    input  wire        reg_wr_i,
    input  wire        reg_rd_i,
    output reg  [31:0] reg_rdata_o,
    // protection stage requests (pins)
    input  wire [4:0]  request_input_i,
    input  wire        critical_request_i,
    input  wire        lockout_reset_i,
    // breaker object
    input  wire        breaker_open_i,
    input  wire        breaker_closed_i,
    input  wire        breaker_fail_i,
    output reg         close_request_o,
    // status
    output reg         recloser_active_o,
    output reg         request2_pending_o,
    output reg         first_attempt_active_o,
    output reg         second_attempt_active_o,
    output reg         global_reclaim_active_o,
    output reg         definitive_open_state_o,
    output reg         recloser_lockout_o,
    output reg         irq_o
);
    // states, one-hot
    localparam [6:0] ST_READY = 7'h01;
    localparam [6:0] ST_TRIP  = 7'h02;
    localparam [6:0] ST_DEAD  = 7'h04;
    localparam [6:0] ST_CLOSE = 7'h08;
    localparam [6:0] ST_RECL  = 7'h10;
    localparam [6:0] ST_GRECL = 7'h20;
    localparam [6:0] ST_LOCK  = 7'h40;

    // synchronisers: three stages, change accepted when 2nd and 3rd agree
    localparam integer NSYNC = 10;
    wire [NSYNC-1:0] raw_in = {breaker_fail_i, breaker_closed_i, breaker_open_i,
                               lockout_reset_i, critical_request_i, request_input_i};
    reg  [NSYNC-1:0] s1, s2, s3, clean;
    genvar g;
    generate
        for (g = 0; g < NSYNC; g = g + 1) begin : g_sync
            always @(posedge ref_clk_i or negedge resetn_i) begin
                if (!resetn_i) begin
                    s1[g]    <= 1'b0;
                    s2[g]    <= 1'b0;
                    s3[g]    <= 1'b0;
                    clean[g] <= 1'b0;
                end else begin
                    s1[g] <= raw_in[g];
                    s2[g] <= s1[g];
                    s3[g] <= s2[g];
                    if (s2[g] == s3[g]) begin
                        clean[g] <= s3[g];
                    end
                end
            end
        end
    endgenerate
    wire [4:0] req      = clean[4:0];
    wire       crit     = clean[5];
    wire       lrst_pin = clean[6];
    wire       brk_open = clean[7];
    wire       brk_cls  = clean[8];
    wire       brk_fail = clean[9];
    wire       any_req  = |req;

    // settings registers
    reg [31:0] ctrl, dead1, dead2, recl1, recl2, grecl, irq_stat, irq_mask;
    wire       shot2_en = ctrl[`ARC_CTRL_SHOT2_EN];

    // ms tick shared by every timer
    wire tick;
    arc_ms_tick #(.TICK_CYC(TICK_CYC)) u_tick (
        .ref_clk_i (ref_clk_i),
        .resetn_i  (resetn_i),
        .tick_o    (tick)
    );

    // sequence state
    reg [6:0]  state, next_state;
    reg        shot;          // 0 first, 1 second
    reg [2:0]  req_id;        // highest-priority request that started the run
    reg [31:0] tmr;
    reg        fail_seen;
    wire       sw_reset = reg_wr_i && (reg_addr_i == `ARC_CTRL_OFS)
                          && reg_wdata_i[`ARC_CTRL_RESET];
    wire [31:0] dead_cur = shot ? dead2 : dead1;
    // where a good cycle goes: global reclaim, or straight to ready
    wire [6:0]  gr_next  = (ctrl[`ARC_CTRL_GR_SKIP] || grecl == 32'h0)
                           ? ST_READY : ST_GRECL;
    wire [31:0] recl_cur = shot ? recl2 : recl1;

    // priority encoder, request 1 highest
    reg [2:0] pri;
    always @* begin
        pri = 3'h0;
        if (req[4]) pri = 3'h5;
        if (req[3]) pri = 3'h4;
        if (req[2]) pri = 3'h3;
        if (req[1]) pri = 3'h2;
        if (req[0]) pri = 3'h1;
    end

    // breaker failure: breaker_fail_i is last sync bit
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) fail_seen <= 1'b0;
        else           fail_seen <= brk_fail;
    end

    // next-state decisions
    always @* begin
        next_state = state;
        case (state)
            ST_READY: if (any_req) next_state = ST_TRIP;
            ST_TRIP:  if (brk_open && !any_req) next_state = ST_DEAD;
            ST_DEAD:  if (tmr >= dead_cur) next_state = ST_CLOSE;
            ST_CLOSE: if (brk_cls) begin
                          next_state = (recl_cur == 32'h0) ? gr_next : ST_RECL;
                      end
            ST_RECL: begin
                if (any_req) begin
                    next_state = (!shot && shot2_en) ? ST_TRIP : ST_LOCK;
                end else if (tmr >= recl_cur) begin
                    next_state = gr_next;
                end
            end
            ST_GRECL: begin
                if (ctrl[`ARC_CTRL_GR_SKIP] || grecl == 32'h0) begin
                    next_state = ST_READY;
                end else if (any_req && ctrl[`ARC_CTRL_GR_LOCK]) begin
                    next_state = ST_LOCK;
                end else if (any_req) begin
                    next_state = ST_TRIP;
                end else if (tmr >= grecl) begin
                    next_state = ST_READY;
                end
            end
            ST_LOCK: if ((lrst_pin || sw_reset) && brk_cls) next_state = ST_READY;
            default: next_state = ST_READY;
        endcase
        if (state != ST_LOCK && (crit || fail_seen)) begin
            next_state = ST_LOCK;
        end
    end

    // a new run starts from ready, or from global reclaim without lock option
    wire start_seq = (state == ST_READY || state == ST_GRECL) && (next_state == ST_TRIP);
    wire run_next  = (next_state == ST_TRIP) || (next_state == ST_DEAD)
                     || (next_state == ST_CLOSE) || (next_state == ST_RECL);
    reg  next_shot;
    // shot index of the coming cycle, shared by state and attempt flags
    always @* begin
        if (next_state == ST_READY || start_seq) begin
            next_shot = 1'b0;
        end else if (state == ST_RECL && next_state == ST_TRIP) begin
            next_shot = 1'b1;
        end else begin
            next_shot = shot;
        end
    end

    // state, shot index and timer
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state  <= ST_READY;
            shot   <= 1'b0;
            req_id <= 3'h0;
            tmr    <= 32'h0;
        end else begin
            state <= next_state;
            if (next_state != state) tmr <= 32'h0;
            else if (tick)           tmr <= tmr + 32'h1;
            shot <= next_shot;
            if (start_seq) req_id <= pri;
            else if (next_state == ST_READY) req_id <= 3'h0;
        end
    end

    // outputs, all registered; flags drop when global reclaim, ready or lockout reached
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            close_request_o         <= 1'b0;
            recloser_active_o       <= 1'b0;
            request2_pending_o      <= 1'b0;
            first_attempt_active_o  <= 1'b0;
            second_attempt_active_o <= 1'b0;
            global_reclaim_active_o <= 1'b0;
            definitive_open_state_o <= 1'b0;
            recloser_lockout_o      <= 1'b0;
        end else begin
            close_request_o <= (next_state == ST_CLOSE);
            recloser_active_o <= run_next;
            if (start_seq)
                request2_pending_o <= (pri == 3'h2);
            else if (next_state == ST_GRECL || next_state == ST_LOCK
                     || next_state == ST_READY)
                request2_pending_o <= 1'b0;
            first_attempt_active_o  <= run_next && !next_shot;
            second_attempt_active_o <= run_next && next_shot;
            global_reclaim_active_o <= (next_state == ST_GRECL);
            definitive_open_state_o <= (next_state == ST_LOCK);
            recloser_lockout_o      <= (next_state == ST_LOCK);
        end
    end

    // interrupt events
    wire [3:0] ev;
    assign ev[`ARC_EV_START]   = start_seq;
    assign ev[`ARC_EV_CLOSE]   = (state == ST_CLOSE) && (next_state != ST_CLOSE);
    assign ev[`ARC_EV_LOCKOUT] = (state != ST_LOCK) && (next_state == ST_LOCK);
    assign ev[`ARC_EV_READY]   = (state != ST_READY) && (next_state == ST_READY);

    // register writes; event set wins over write-one clear
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            ctrl     <= `ARC_CTRL_RST;
            dead1    <= `ARC_DEAD1_RST;
            dead2    <= `ARC_DEAD2_RST;
            recl1    <= `ARC_RECL_RST;
            recl2    <= `ARC_RECL_RST;
            grecl    <= `ARC_GRECL_RST;
            irq_stat <= 32'h0;
            irq_mask <= 32'h0;
        end else begin
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `ARC_CTRL_OFS:     ctrl  <= {28'h0, reg_wdata_i[3:0]};
                    `ARC_DEAD1_OFS:    dead1 <= reg_wdata_i;
                    `ARC_DEAD2_OFS:    dead2 <= reg_wdata_i;
                    `ARC_RECL1_OFS:    recl1 <= reg_wdata_i;
                    `ARC_RECL2_OFS:    recl2 <= reg_wdata_i;
                    `ARC_GRECL_OFS:    grecl <= reg_wdata_i;
                    `ARC_IRQ_MASK_OFS: irq_mask <= {28'h0, reg_wdata_i[3:0]};
                    default: ;
                endcase
            end
            irq_stat <= (irq_stat & ~((reg_wr_i && reg_addr_i == `ARC_IRQ_STAT_OFS)
                        ? {28'h0, reg_wdata_i[3:0]} : 32'h0)) | {28'h0, ev};
        end
    end

    // read data one cycle later; unmapped reads zero
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            reg_rdata_o <= 32'h0;
            irq_o       <= 1'b0;
        end else begin
            irq_o <= |(irq_stat & irq_mask);
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `ARC_CTRL_OFS:     reg_rdata_o <= ctrl;
                    `ARC_STATUS_OFS:   reg_rdata_o <= {19'h0, req_id, shot, 2'h0, state};
                    `ARC_IRQ_STAT_OFS: reg_rdata_o <= irq_stat;
                    `ARC_IRQ_MASK_OFS: reg_rdata_o <= irq_mask;
                    `ARC_DEAD1_OFS:    reg_rdata_o <= dead1;
                    `ARC_DEAD2_OFS:    reg_rdata_o <= dead2;
                    `ARC_RECL1_OFS:    reg_rdata_o <= recl1;
                    `ARC_RECL2_OFS:    reg_rdata_o <= recl2;
                    `ARC_GRECL_OFS:    reg_rdata_o <= grecl;
                    default:           reg_rdata_o <= 32'h0;
                endcase
            end else begin
                reg_rdata_o <= 32'h0;
            end
        end
    end
endmodule

// File: tb/arc_sequencer_properties.sv
module arc_sequencer_properties #(
    parameter integer TICK_CYC = 40000
) (
    // clock and reset
    input logic ref_clk_i,
    input logic resetn_i,
    // pins
    input logic critical_request_i,
    input logic breaker_closed_i,
    input logic breaker_fail_i,
    // outputs watched
    input logic close_request_o,
    input logic recloser_active_o,
    input logic request2_pending_o,
    input logic first_attempt_active_o,
    input logic second_attempt_active_o,
    input logic global_reclaim_active_o,
    input logic definitive_open_state_o,
    input logic recloser_lockout_o
);
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    // input filters cost about five cycles, so ten is the margin
    chk_close_drop: assert property (close_request_o && breaker_closed_i |->
        ##[1:10] !close_request_o) else $error("close held after breaker closed");
    chk_lock_no_close: assert property (recloser_lockout_o && $past(recloser_lockout_o)
        |-> !close_request_o) else $error("close request during lockout");
    chk_final_flags: assert property (definitive_open_state_o |-> !recloser_active_o
        && !second_attempt_active_o && !request2_pending_o) else $error("final trip flags");
    chk_shot_excl: assert property (!(first_attempt_active_o && second_attempt_active_o))
        else $error("both attempts active");
    chk_request_input_2_start: assert property ($rose(request2_pending_o) |->
        $rose(recloser_active_o) && first_attempt_active_o) else $error("start flags apart");
    chk_fail_lock: assert property ($rose(breaker_fail_i) |-> ##[1:10] recloser_lockout_o)
        else $error("no lockout on breaker failure");
    chk_crit_lock: assert property ($rose(critical_request_i) && recloser_active_o |->
        ##[1:10] recloser_lockout_o) else $error("no lockout on critical request");
    chk_grecl_idle: assert property (global_reclaim_active_o |-> !recloser_active_o
        && !close_request_o) else $error("global reclaim while running");
    chk_close_active: assert property (close_request_o |-> recloser_active_o)
        else $error("close request while idle");
    chk_lock_hold: assert property ((!breaker_closed_i) [*8] ##0 recloser_lockout_o
        |=> recloser_lockout_o) else $error("lockout left open");
endmodule

// File: tb/arc_breaker_model.sv
module arc_breaker_model #(
    parameter int DLY = 3
) (
    // clock and reset
    input  wire logic ref_clk_i,
    input  wire logic resetn_i,
    // commands from stage, sequencer and operator
    input  wire logic open_cmd_i,
    input  wire logic close_req_i,
    input  wire logic man_close_i,
    input  wire logic fail_en_i,
    // breaker status
    output logic      closed_o,
    output logic      fail_o
);
    timeunit 1ns;
    timeprecision 100ps;
    int cnt;
    wire logic move = closed_o ? open_cmd_i : (close_req_i | man_close_i);
    // a command must be held DLY+1 cycles before the contacts move
    always @(posedge ref_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            closed_o <= 1'b1;
            fail_o   <= 1'b0;
            cnt      <= 0;
        end else if (!move) begin
            cnt    <= 0;
            fail_o <= 1'b0;
        end else if (cnt < DLY) begin
            cnt <= cnt + 1;
        end else if (close_req_i && fail_en_i) begin
            fail_o <= 1'b1;
        end else begin
            cnt      <= 0;
            closed_o <= !closed_o;
        end
    end
endmodule

// File: tb/arc_sequencer_test.sv
`include "arc_regs.vh"
module arc_sequencer_test;
    timeunit 1ns;
    timeprecision 100ps;
    localparam int TICK = 4;
    logic        ref_clk_i = 1'b0;
    logic        resetn_i = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0, rd = 1'b0, crit = 1'b0, lrst = 1'b0, man = 1'b0, fail_en = 1'b0;
    logic [4:0]  req = 5'h00;
    logic [31:0] v;
    int          n_gr;
    wire  [31:0] rdata;
    wire         closed, fail, close_req, act, request_input_2, first, second, grecl, defo, lock, irq;
    wire  [9:0]  st = {!closed, irq, close_req, lock, defo, grecl, second, first, request_input_2, act};
    int          num_errors = 0, tests_run = 0, n;
    always #12.5 ref_clk_i = ~ref_clk_i;
    // counts cycles with global reclaim shown, so a one-cycle blip is caught
    always @(posedge ref_clk_i) begin
        if (!resetn_i) n_gr <= 0;
        else if (grecl) n_gr <= n_gr + 1;
    end
    arc_sequencer #(.TICK_CYC(TICK)) arc_sequencer_i (.ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i), .reg_addr_i(addr), .reg_wdata_i(wdata), .reg_wr_i(wr),
        .reg_rd_i(rd), .reg_rdata_o(rdata), .request_input_i(req), .critical_request_i(crit),
        .lockout_reset_i(lrst), .breaker_open_i(!closed), .breaker_closed_i(closed),
        .breaker_fail_i(fail), .close_request_o(close_req), .recloser_active_o(act),
        .request2_pending_o(request_input_2), .first_attempt_active_o(first),
        .second_attempt_active_o(second), .global_reclaim_active_o(grecl),
        .definitive_open_state_o(defo), .recloser_lockout_o(lock), .irq_o(irq));
    arc_breaker_model arc_breaker_model_i (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
        .open_cmd_i(|req), .close_req_i(close_req), .man_close_i(man), .fail_en_i(fail_en),
        .closed_o(closed), .fail_o(fail));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge ref_clk_i);
        wr <= 1'b0;
        @(posedge ref_clk_i);
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        addr <= a;
        rd   <= 1'b1;
        @(posedge ref_clk_i);
        rd <= 1'b0;
        #1 v = rdata;
        chk(nm, exp, v);
        @(posedge ref_clk_i);
    endtask
    // sampled at the falling edge, where outputs have settled
    task automatic wait_st(input int b, input logic val);
        n = 0;
        do begin
            @(negedge ref_clk_i);
            n++;
        end while (st[b] !== val && n < 500);
        chk($sformatf("status bit %0d", b), val, st[b]);
        @(posedge ref_clk_i);
    endtask
    // one shot: stage trips on request 2, breaker opens, dead time, close
    task automatic shot(input int dead);
        req <= 5'h02;
        wait_st(9, 1'b1);
        req <= 5'h00;
        wait_st(7, 1'b1);
        chk("dead time", 1, n >= dead * TICK - 4 && n <= dead * TICK + 12);
        wait_st(7, 1'b0);
    endtask
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial begin
        #(25 * 30000);
        num_errors++;
        end_of_test;
    end
    initial begin
        repeat (12) @(posedge ref_clk_i);
        resetn_i <= 1'b1;
        @(posedge ref_clk_i);
        rchk("ctrl", `ARC_CTRL_OFS, 32'h0000_0007);
        rchk("dead1", `ARC_DEAD1_OFS, 32'h0000_00c8);
        rchk("dead2", `ARC_DEAD2_OFS, 32'h0000_ea60);
        rchk("recl2", `ARC_RECL2_OFS, 32'h0000_2710);
        rchk("grecl", `ARC_GRECL_OFS, 32'h0000_2710);
        wr_reg(8'h40, 32'hffff_ffff);
        rchk("unmapped", 8'h40, 32'h0);
        wr_reg(`ARC_DEAD1_OFS, 32'h5);
        wr_reg(`ARC_DEAD2_OFS, 32'hc);
        wr_reg(`ARC_RECL1_OFS, 32'ha);
        wr_reg(`ARC_RECL2_OFS, 32'ha);
        wr_reg(`ARC_GRECL_OFS, 32'ha);
        wr_reg(`ARC_IRQ_MASK_OFS, 32'hf);
        shot(5);
        chk("after shot 1", 4'b0111, st[3:0]);
        shot(12);
        chk("after shot 2", 4'b1011, st[3:0]);
        req <= 5'h02;
        wait_st(6, 1'b1);
        chk("final trip", 7'b1100000, st[6:0]);
        wait_st(9, 1'b1);
        req <= 5'h00;
        rchk("irq status", `ARC_IRQ_STAT_OFS, 32'h7);
        chk("irq line", 1, irq);
        wr_reg(`ARC_IRQ_STAT_OFS, 32'h7);
        rchk("irq cleared", `ARC_IRQ_STAT_OFS, 32'h0);
        chk("irq line low", 0, irq);
        req  <= 5'h02;
        lrst <= 1'b1;
        repeat (40) @(posedge ref_clk_i);
        chk("lockout held", 2'b01, st[7:6]);
        req <= 5'h00;
        man <= 1'b1;
        wait_st(6, 1'b0);
        man  <= 1'b0;
        lrst <= 1'b0;
        rchk("shot index", `ARC_STATUS_OFS, 32'h0000_0001);
        $display("test both shots fail done");
        wr_reg(`ARC_IRQ_STAT_OFS, 32'hf);
        wr_reg(`ARC_IRQ_MASK_OFS, 32'h0);
        shot(5);
        wait_st(0, 1'b0);
        chk("reclaim over", 5'b10000, st[4:0]);
        wait_st(4, 1'b0);
        rchk("events", `ARC_IRQ_STAT_OFS, 32'hb);
        chk("masked irq", 0, irq);
        wr_reg(`ARC_IRQ_MASK_OFS, 32'h8);
        repeat (2) @(posedge ref_clk_i);
        chk("unmasked irq", 1, irq);
        wr_reg(`ARC_IRQ_STAT_OFS, 32'hf);
        repeat (2) @(posedge ref_clk_i);
        chk("irq after clear", 0, irq);
        $display("test first shot succeeds done");
        shot(5);
        wait_st(4, 1'b1);
        req <= 5'h02;
        wait_st(6, 1'b1);
        chk("fault in global reclaim", 3'b110, st[6:4]);
        wait_st(9, 1'b1);
        req <= 5'h00;
        man <= 1'b1;
        wait_st(9, 1'b0);
        repeat (10) @(posedge ref_clk_i);
        wr_reg(`ARC_CTRL_OFS, 32'h17);
        wait_st(6, 1'b0);
        man <= 1'b0;
        $display("test global reclaim lockout done");
        wr_reg(`ARC_CTRL_OFS, 32'h0b);
        wr_reg(`ARC_RECL1_OFS, 32'h0);
        v = n_gr;
        shot(5);
        repeat (20) @(negedge ref_clk_i);
        chk("zero reclaim, no global", 2'b00, {n_gr != v, act});
        @(posedge ref_clk_i);
        $display("test timers bypassed done");
        fail_en <= 1'b1;
        req     <= 5'h02;
        wait_st(9, 1'b1);
        req <= 5'h00;
        wait_st(6, 1'b1);
        fail_en <= 1'b0;
        man     <= 1'b1;
        lrst    <= 1'b1;
        wait_st(6, 1'b0);
        man  <= 1'b0;
        lrst <= 1'b0;
        req  <= 5'h02;
        wait_st(0, 1'b1);
        crit <= 1'b1;
        wait_st(6, 1'b1);
        crit <= 1'b0;
        req  <= 5'h00;
        $display("test failure and critical done");
        end_of_test;
    end
endmodule
bind arc_sequencer arc_sequencer_properties #(.TICK_CYC(TICK_CYC)) arc_sequencer_properties_i (
    .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .critical_request_i(critical_request_i),
    .breaker_closed_i(breaker_closed_i), .breaker_fail_i(breaker_fail_i),
    .close_request_o(close_request_o), .recloser_active_o(recloser_active_o),
    .request2_pending_o(request2_pending_o), .first_attempt_active_o(first_attempt_active_o),
    .second_attempt_active_o(second_attempt_active_o),
    .global_reclaim_active_o(global_reclaim_active_o),
    .definitive_open_state_o(definitive_open_state_o), .recloser_lockout_o(recloser_lockout_o));
